/* File: hw/gen_signal_map.vh */
// register offsets, field layout and reset values of the general signal router
`ifndef GEN_SIGNAL_MAP_VH
`define GEN_SIGNAL_MAP_VH

// selector words: four 5-bit selectors per word, one per byte lane
`define GSM_DIN_SEL0      8'h00
`define GSM_DIN_SEL1      8'h04
`define GSM_DOUT_SEL0     8'h08
`define GSM_DOUT_SEL1     8'h0C
`define GSM_RIN_SEL0      8'h10
`define GSM_RIN_SEL3      8'h1C
`define GSM_ROUT_SEL0     8'h20
`define GSM_ROUT_SEL3     8'h2C
`define GSM_EVT_SEL       8'h30
`define GSM_DIN_INV       8'h34
`define GSM_DOUT_INV      8'h38
`define GSM_RIN_DATA      8'h3C
`define GSM_ROUT_DATA     8'h40
`define GSM_GEN_STATE     8'h44
`define GSM_INT_STATUS    8'h48
`define GSM_INT_CLEAR     8'h4C
`define GSM_INT_ENABLE    8'h50

// selector word indices inside the configuration array
`define GSM_IDX_DIN       4'd0
`define GSM_IDX_DOUT      4'd2
`define GSM_IDX_RIN       4'd4
`define GSM_IDX_ROUT      4'd8
`define GSM_IDX_EVT       4'd12
`define GSM_CFG_WORDS     13

// field layout
`define GSM_SEL_W         5
`define GSM_SEL_MASK      32'h1F1F1F1F
`define GSM_SEL_NONE      5'h1F
`define GSM_INV_RESET     32'h00000000
`define GSM_DOUT_BASE     5'h08

`endif

/* File: hw/general_signal_remote_io_map.v */
// general signal router between direct pins, remote bits and event triggers
//
// Behaviour
// - sixteen general signals, each assignable to direct and remote slots.
// - remote input bit mapped with direct output drives that output on/off.
// - direct input mapped with remote output bit reports 1 on, 0 off.
// - each direct input has polarity bit, 1 inverts, default 0.
// - each direct output has polarity bit, 1 inverts, default 0.
// - general signal as event source raises entry event when direct input turns on.
// - each direct slot has a function selector with per-slot default.
// - each remote bit has a function selector with per-bit default.
//
// register map, byte offsets of 32-bit words; unused bits read zero, writes to them are lost
//   0x00 0x04  direct input selectors, slots 0-3 and 4-7, one per byte lane
//   0x08 0x0C  direct output selectors, slots 0-3 and 4-7
//   0x10-0x1C  remote input bit selectors, bits 0-15, four per word
//   0x20-0x2C  remote output bit selectors, bits 0-15, four per word
//   0x30       event trigger source of sequence entries 0-3
//   0x34       direct input polarity, 1 inverts
//   0x38       direct output polarity, 1 inverts
//   0x3C       remote input bits written by the master
//   0x40       remote output bits, read only
//   0x44       general signal state, read only
//   0x48       sticky event status, read only
//   0x4C       event status clear, write 1 to clear, reads zero
//   0x50       event interrupt enable
//   other      acknowledged, read zero, writes ignored
//
// selector byte: 0-15 names a general signal, 16-31 leaves the slot unassigned;
// bits 7:5 of every selector byte read zero
//
// limitations: an unassigned output slot is off before its polarity bit;
// events see only the direct input share of a general signal, never a remote bit;
// a pin change takes five to six edges to reach the outputs, through the synchroniser
//
// Register access over Wishbone and the address map were chosen for this implementation.
`include "gen_signal_map.vh"

module general_signal_remote_io_map #(
  parameter NUM_GEN  = 16,
  parameter NUM_DIN  = 8,
  parameter NUM_DOUT = 8,
  parameter NUM_RIO  = 16,
  parameter NUM_EVT  = 4
) (
  input  wire                ref_clk,
  input  wire                rst,
  // register bus
  input  wire                wb_cyc_i,
  input  wire                wb_stb_i,
  input  wire                wb_we_i,
  input  wire [7:0]          wb_adr_i,
  input  wire [3:0]          wb_sel_i,
  input  wire [31:0]         wb_dat_i,
  output reg  [31:0]         wb_dat_o,
  output reg                 wb_ack_o,
  // field pins
  input  wire [NUM_DIN-1:0]  directIn,
  output reg  [NUM_DOUT-1:0] directOut,
  // sequencer events and interrupt
  output reg  [NUM_EVT-1:0]  eventPulse,
  output reg                 irq
);

  ////////////////////////////////////////////////////////////////////////////
  // storage

  // selector words, polarity, remote inputs and event registers
  reg  [31:0]         cfg_r [0:`GSM_CFG_WORDS-1];
  reg  [NUM_DIN-1:0]  dinInv_r;
  reg  [NUM_DOUT-1:0] doutInv_r;
  reg  [NUM_RIO-1:0]  remoteIn_r;
  reg  [NUM_RIO-1:0]  remoteOut_r;
  reg  [NUM_EVT-1:0]  intStatus_r;
  reg  [NUM_EVT-1:0]  intEnable_r;
  // pin synchroniser and edge history
  reg  [NUM_DIN-1:0]  sync1_r;
  reg  [NUM_DIN-1:0]  sync2_r;
  reg  [NUM_DIN-1:0]  sync3_r;
  reg  [NUM_DIN-1:0]  dinStable_r;
  reg  [NUM_GEN-1:0]  dinGenPrev_r;
  reg  [NUM_GEN-1:0]  genState_r;

  // combinational routing terms and loop indices, two for the routing process, one each for the output, synchroniser and bus processes
  reg  [NUM_DIN-1:0]  dinPol;
  reg  [NUM_GEN-1:0]  dinGen;
  reg  [NUM_GEN-1:0]  genSig;
  reg  [NUM_DOUT-1:0] directOut_nxt;
  reg  [NUM_RIO-1:0]  remoteOut_nxt;
  reg  [NUM_EVT-1:0]  eventHit;
  reg  [31:0]         rdData;
  reg  [4:0]          selVal;
  integer             i;
  integer             j;
  integer             k;
  integer             s;
  integer             c;

  // bus decode; the ack term keeps a request that is still held from being taken again while ack is high
  wire                busReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire                busWr   = busReq & wb_we_i;
  wire                cfgHit  = (wb_adr_i[7:2] < `GSM_CFG_WORDS);
  wire [3:0]          cfgIdx  = wb_adr_i[5:2];
  wire [31:0]         laneMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire                clrWr   = busWr & (wb_adr_i == `GSM_INT_CLEAR);
  // polarity reset value, trimmed to the slot count where it is used
  wire [31:0]         invReset = `GSM_INV_RESET;

  // flat copy of the selector words: passed to selOf as an argument, so that
  // every routing process wakes on a selector write
  wire [32*`GSM_CFG_WORDS-1:0] cfgFlat;
  genvar              g;
  generate
    for (g = 0; g < `GSM_CFG_WORDS; g = g + 1) begin : gFlat
      assign cfgFlat[32*g +: 32] = cfg_r[g];
    end
  endgenerate

  // selector of slot n in a group starting at word base
  // four selectors share a word, so slot n sits in byte n[1:0] of word base + n/4
  function [4:0] selOf;
    input [32*`GSM_CFG_WORDS-1:0] all;
    input [3:0]                   base;
    input [4:0]                   n;
    reg   [3:0]                   word;
    begin
      word  = base + {1'b0, n[4:2]};
      selOf = all[{word, n[1:0], 3'b000} +: 5];
    end
  endfunction

  // reset default of selector word w; defaults differ per slot
  // direct inputs and both remote groups start one-to-one, direct outputs at signal 8,
  // event sources start unassigned so that no entry fires before it is set up
  function [31:0] cfgDefault;
    input [3:0] w;
    reg   [4:0] first;
    begin
      if (w < `GSM_IDX_DOUT) begin
        first = {w[2:0], 2'b00};
      end else if (w < `GSM_IDX_RIN) begin
        first = `GSM_DOUT_BASE + {w[2:0] - 3'd2, 2'b00};
      end else if (w < `GSM_IDX_ROUT) begin
        first = {w[2:0] - 3'd4, 2'b00};
      end else if (w < `GSM_IDX_EVT) begin
        first = {w[2:0], 2'b00};
      end else begin
        first = `GSM_SEL_NONE;
      end
      if (first == `GSM_SEL_NONE) begin
        cfgDefault = {4{3'b000, `GSM_SEL_NONE}};
      end else begin
        cfgDefault = {3'b000, first + 5'd3, 3'b000, first + 5'd2, 3'b000, first + 5'd1, 3'b000, first};
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser: a change is taken once the second and third stages agree
  // the first stage may go metastable, so only the second stage reads it;
  // a pin that chatters faster than the clock holds its last agreed level

  always @(posedge ref_clk) begin
    if (rst) begin
      sync1_r     <= {NUM_DIN{1'b0}};
      sync2_r     <= {NUM_DIN{1'b0}};
      sync3_r     <= {NUM_DIN{1'b0}};
      dinStable_r <= {NUM_DIN{1'b0}};
    end else begin
      sync1_r <= directIn;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      for (s = 0; s < NUM_DIN; s = s + 1) begin
        if (sync2_r[s] == sync3_r[s]) begin
          dinStable_r[s] <= sync3_r[s];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // routing: general signal k is the OR of every direct input slot and remote input bit whose selector names k
  // several slots naming one signal are ORed, so none can mask another;
  // dinGen keeps the direct input share apart, since only that share may trigger events

  always @* begin
    dinPol = dinStable_r ^ dinInv_r;
    dinGen = {NUM_GEN{1'b0}};
    genSig = {NUM_GEN{1'b0}};
    for (k = 0; k < NUM_GEN; k = k + 1) begin
      for (i = 0; i < NUM_DIN; i = i + 1) begin
        if (selOf(cfgFlat, `GSM_IDX_DIN, i[4:0]) == k[4:0] && dinPol[i]) begin
          dinGen[k] = 1'b1;
        end
      end
      genSig[k] = dinGen[k];
      for (i = 0; i < NUM_RIO; i = i + 1) begin
        if (selOf(cfgFlat, `GSM_IDX_RIN, i[4:0]) == k[4:0] && remoteIn_r[i]) begin
          genSig[k] = 1'b1;
        end
      end
    end
  end

  // outputs pick one general signal each; unassigned selectors give off
  // an unassigned direct output still follows its polarity bit, so a 1 there idles high
  always @* begin
    for (j = 0; j < NUM_DOUT; j = j + 1) begin
      selVal = selOf(cfgFlat, `GSM_IDX_DOUT, j[4:0]);
      directOut_nxt[j] = (~selVal[4] & genSig[selVal[3:0]]) ^ doutInv_r[j];
    end
    for (j = 0; j < NUM_RIO; j = j + 1) begin
      selVal = selOf(cfgFlat, `GSM_IDX_ROUT, j[4:0]);
      remoteOut_nxt[j] = ~selVal[4] & genSig[selVal[3:0]];
    end
    for (j = 0; j < NUM_EVT; j = j + 1) begin
      selVal = selOf(cfgFlat, `GSM_IDX_EVT, j[4:0]);
      // only a direct input turning on triggers, not a remote bit
      eventHit[j] = ~selVal[4] & dinGen[selVal[3:0]] & ~dinGenPrev_r[selVal[3:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs, events and interrupt status

  always @(posedge ref_clk) begin
    if (rst) begin
      directOut    <= {NUM_DOUT{1'b0}};
      remoteOut_r  <= {NUM_RIO{1'b0}};
      genState_r   <= {NUM_GEN{1'b0}};
      dinGenPrev_r <= {NUM_GEN{1'b0}};
      eventPulse   <= {NUM_EVT{1'b0}};
      intStatus_r  <= {NUM_EVT{1'b0}};
      irq          <= 1'b0;
    end else begin
      directOut    <= directOut_nxt;
      remoteOut_r  <= remoteOut_nxt;
      genState_r   <= genSig;
      dinGenPrev_r <= dinGen;
      eventPulse   <= eventHit;
      // a new event wins over a clear in the same cycle
      // the clear word is taken whole, byte lanes do not gate it
      intStatus_r  <= (intStatus_r & ~(clrWr ? wb_dat_i[NUM_EVT-1:0] : {NUM_EVT{1'b0}})) | eventHit;
      // irq follows the registered status one edge later, so it cannot glitch
      irq          <= |(intStatus_r & intEnable_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, ack for one cycle, unmapped reads zero
  // a write lands at the edge that raises ack; a master that keeps stb up after ack
  // is answered again two edges later, so the request must drop once ack is seen

  always @(posedge ref_clk) begin
    if (rst) begin
      for (c = 0; c < `GSM_CFG_WORDS; c = c + 1) begin
        cfg_r[c] <= cfgDefault(c[3:0]);
      end
      dinInv_r    <= invReset[NUM_DIN-1:0];
      doutInv_r   <= invReset[NUM_DOUT-1:0];
      remoteIn_r  <= {NUM_RIO{1'b0}};
      intEnable_r <= {NUM_EVT{1'b0}};
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h00000000;
    end else begin
      wb_ack_o <= busReq;
      wb_dat_o <= busReq ? rdData : 32'h00000000;
      if (busWr) begin
        if (cfgHit) begin
          cfg_r[cfgIdx] <= ((cfg_r[cfgIdx] & ~laneMask) | (wb_dat_i & laneMask)) & `GSM_SEL_MASK;
        end
        // polarity, remote input and enable words honour the byte lanes
        case (wb_adr_i)
          `GSM_DIN_INV: begin
            dinInv_r <= (dinInv_r & ~laneMask[NUM_DIN-1:0]) | (wb_dat_i[NUM_DIN-1:0] & laneMask[NUM_DIN-1:0]);
          end
          `GSM_DOUT_INV: begin
            doutInv_r <= (doutInv_r & ~laneMask[NUM_DOUT-1:0]) | (wb_dat_i[NUM_DOUT-1:0] & laneMask[NUM_DOUT-1:0]);
          end
          `GSM_RIN_DATA: begin
            remoteIn_r <= (remoteIn_r & ~laneMask[NUM_RIO-1:0]) | (wb_dat_i[NUM_RIO-1:0] & laneMask[NUM_RIO-1:0]);
          end
          `GSM_INT_ENABLE: begin
            intEnable_r <= (intEnable_r & ~laneMask[NUM_EVT-1:0]) | (wb_dat_i[NUM_EVT-1:0] & laneMask[NUM_EVT-1:0]);
          end
          default: begin
          end
        endcase
      end
    end
  end

  // read mux; write-only clear and unmapped addresses read zero
  // the mux is combinational; wb_dat_o registers it in the cycle that raises ack
  always @* begin
    rdData = 32'h00000000;
    if (cfgHit) begin
      rdData = cfg_r[cfgIdx];
    end else begin
      case (wb_adr_i)
        `GSM_DIN_INV:    rdData[NUM_DIN-1:0]  = dinInv_r;
        `GSM_DOUT_INV:   rdData[NUM_DOUT-1:0] = doutInv_r;
        `GSM_RIN_DATA:   rdData[NUM_RIO-1:0]  = remoteIn_r;
        `GSM_ROUT_DATA:  rdData[NUM_RIO-1:0]  = remoteOut_r;
        `GSM_GEN_STATE:  rdData[NUM_GEN-1:0]  = genState_r;
        `GSM_INT_STATUS: rdData[NUM_EVT-1:0]  = intStatus_r;
        `GSM_INT_ENABLE: rdData[NUM_EVT-1:0]  = intEnable_r;
        default:         rdData = 32'h00000000;
      endcase
    end
  end

endmodule

/* File: sim/gsm_chk.sv */
// port checker for the general signal router
`include "gen_signal_map.vh"
module gsm_chk #(
  parameter NUM_EVT = 4
) (
  input logic               ref_clk,
  input logic               rst,
  input logic               wb_cyc_i,
  input logic               wb_stb_i,
  input logic               wb_we_i,
  input logic [7:0]         wb_adr_i,
  input logic [31:0]        wb_dat_o,
  input logic               wb_ack_o,
  input logic [NUM_EVT-1:0] eventPulse,
  input logic               irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // a request counts only once the previous answer has gone
  wire newReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire newRd  = newReq && !wb_we_i;
  wire wrDone = wb_ack_o && wb_we_i;
  ////////////////////////////////////////////////////////////////
  property p_ackNext; newReq |=> wb_ack_o; endproperty
  a_ackNext: assert property (p_ackNext) else $error("no ack");
  property p_ackOnce; wb_ack_o |=> !wb_ack_o; endproperty
  a_ackOnce: assert property (p_ackOnce) else $error("ack too long");
  property p_datIdle; !wb_ack_o |-> wb_dat_o == 32'h00000000; endproperty
  a_datIdle: assert property (p_datIdle) else $error("data without ack");
  property p_refused; newRd && (wb_adr_i == 8'hFC || wb_adr_i == `GSM_INT_CLEAR) |=> wb_dat_o == 32'h0; endproperty
  a_refused: assert property (p_refused) else $error("nonzero read");
  // selector bytes only hold five bits; upper bits must read zero
  property p_selW; newRd && wb_adr_i <= `GSM_EVT_SEL |=> (wb_dat_o & ~`GSM_SEL_MASK) == 32'h0; endproperty
  a_selW: assert property (p_selW) else $error("selector width");
  property p_invW; newRd && (wb_adr_i == `GSM_DIN_INV) |=> wb_dat_o[31:8] == 24'h0; endproperty
  a_invW: assert property (p_invW) else $error("polarity width");
  property p_evtOnce; (eventPulse & $past(eventPulse)) == '0; endproperty
  a_evtOnce: assert property (p_evtOnce) else $error("event pulse too long");
  // irq moves only one edge after an event or a register write
  property p_irqRise; $rose(irq) |-> $past(eventPulse != '0 || wrDone); endproperty
  a_irqRise: assert property (p_irqRise) else $error("irq rose alone");
  property p_irqFall; $fell(irq) |-> $past(wrDone); endproperty
  a_irqFall: assert property (p_irqFall) else $error("irq fell alone");
  c_write: cover property (wrDone);
  c_event: cover property (eventPulse != '0);
  c_irq: cover property ($rose(irq));
endmodule

bind general_signal_remote_io_map gsm_chk #(.NUM_EVT(NUM_EVT)) chk (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .eventPulse, .irq);

/* File: sim/field_dev.sv */
// field device model: switch contacts and output loads
module field_dev (
  input  logic       ref_clk,
  input  logic [7:0] pinCmd,
  input  logic [7:0] directOut,
  output logic [7:0] directIn,
  output logic [7:0] loadSeen
);
  timeunit 1ns;
  timeprecision 1ps;
  initial directIn = 8'h00;
  // contacts switch one edge late; the router must resynchronise them
  always @(posedge ref_clk) begin
    directIn <= pinCmd;
    loadSeen <= directOut;
  end
endmodule

/* File: sim/testbench.sv */
// self-checking bench for the general signal router
`include "gen_signal_map.vh"
`define CHK(got, exp) begin \
  checked++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("[ERR] %0t got %h exp %h", $time, got, exp); \
  end \
end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic [7:0]  adr     = 8'h00;
  logic [3:0]  sel     = 4'h0;
  logic [31:0] wdat    = 32'h0;
  logic [7:0]  pinCmd  = 8'h00;
  logic [31:0] rdOut, rdat;
  logic [7:0]  directIn, directOut, loadSeen;
  logic [3:0]  eventPulse;
  logic        ack, irq;
  int          errors  = 0;
  int          checked = 0;
  int          n;
  // 50 MHz reference
  always #10 ref_clk = ~ref_clk;
  general_signal_remote_io_map uut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdOut), .wb_ack_o(ack),
    .directIn(directIn), .directOut(directOut), .eventPulse(eventPulse), .irq(irq));
  field_dev dev (.ref_clk(ref_clk), .pinCmd(pinCmd), .directOut(directOut), .directIn(directIn),
    .loadSeen(loadSeen));
  ////////////////////////////////////////////////////////////////
  // one classic cycle, held until ack is sampled; data taken at that edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hF, d};
    do @(posedge ref_clk); while (ack !== 1'b1);
    rdat = rdOut;
    {cyc, stb, we} <= 3'b000;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask
  // counts lone pulses of entry zero; other entries stay unassigned
  task automatic count(output int c);
    c = 0;
    repeat (12) begin
      @(posedge ref_clk);
      c += (eventPulse === 4'h1);
    end
  endtask
  task automatic t_defaults();
    rd(`GSM_DIN_SEL1, 32'h07060504);
    rd(`GSM_DOUT_SEL0, 32'h0B0A0908);
    rd(`GSM_RIN_SEL3, 32'h0F0E0D0C);
    rd(`GSM_ROUT_SEL0, 32'h03020100);
    rd(`GSM_DIN_INV, `GSM_INV_RESET);
    rd(`GSM_DOUT_INV, `GSM_INV_RESET);
    bus(1'b1, 8'hFC, 32'hFFFFFFFF);
    rd(8'hFC, 32'h0);
    bus(1'b1, `GSM_EVT_SEL, 32'hFFFFFFFF);
    rd(`GSM_EVT_SEL, `GSM_SEL_MASK);
    $display("t_defaults done");
  endtask
  task automatic t_remote_out();
    bus(1'b1, `GSM_RIN_DATA, 32'h0000A500);
    repeat (3) @(posedge ref_clk);
    `CHK(loadSeen, 8'hA5)
    rd(`GSM_ROUT_DATA, 32'h0000A500);
    bus(1'b1, `GSM_DOUT_INV, 32'h0F);
    bus(1'b1, `GSM_RIN_DATA, 32'h0);
    repeat (3) @(posedge ref_clk);
    `CHK(directOut, 8'h0F)
    bus(1'b1, `GSM_DOUT_INV, 32'h0);
    $display("t_remote_out done");
  endtask
  task automatic t_din_remote();
    pinCmd <= 8'h81;
    repeat (8) @(posedge ref_clk);
    rd(`GSM_ROUT_DATA, 32'h81);
    bus(1'b1, `GSM_DIN_INV, 32'hFF);
    repeat (8) @(posedge ref_clk);
    rd(`GSM_ROUT_DATA, 32'h7E);
    pinCmd <= 8'h00;
    bus(1'b1, `GSM_DIN_INV, 32'h0);
    repeat (8) @(posedge ref_clk);
    rd(`GSM_GEN_STATE, 32'h0);
    $display("t_din_remote done");
  endtask
  // remapped slots: a new source for a direct output beside unassigned slots, then new sources for remote bits
  task automatic t_remap();
    bus(1'b1, `GSM_DOUT_SEL0, 32'h1F1F1F00);
    bus(1'b1, `GSM_DOUT_INV, 32'h02);
    bus(1'b1, `GSM_RIN_DATA, 32'h1);
    repeat (3) @(posedge ref_clk);
    `CHK(directOut, 8'h03)
    bus(1'b1, `GSM_DOUT_INV, 32'h0);
    bus(1'b1, `GSM_DOUT_SEL0, 32'h0B0A0908);
    bus(1'b1, `GSM_RIN_SEL0, 32'h1F1F1F03);
    bus(1'b1, `GSM_ROUT_SEL0, 32'h1F1F1F05);
    pinCmd <= 8'h20;
    repeat (8) @(posedge ref_clk);
    rd(`GSM_GEN_STATE, 32'h28);
    rd(`GSM_ROUT_DATA, 32'h21);
    pinCmd <= 8'h00;
    bus(1'b1, `GSM_RIN_DATA, 32'h0);
    $display("t_remap done");
  endtask
  task automatic t_event_irq();
    bus(1'b1, `GSM_EVT_SEL, 32'h1F1F1F02);
    bus(1'b1, `GSM_INT_ENABLE, 32'h1);
    pinCmd <= 8'h04;
    count(n);
    `CHK(n, 1)
    `CHK(irq, 1'b1)
    bus(1'b1, `GSM_INT_ENABLE, 32'h0);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b0)
    rd(`GSM_INT_STATUS, 32'h1);
    bus(1'b1, `GSM_INT_ENABLE, 32'h1);
    bus(1'b1, `GSM_INT_CLEAR, 32'h1);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, 1'b0)
    rd(`GSM_INT_STATUS, 32'h0);
    bus(1'b1, `GSM_DIN_INV, 32'h04);
    repeat (8) @(posedge ref_clk);
    pinCmd <= 8'h00;
    count(n);
    `CHK(n, 1)
    $display("t_event_irq done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // main sequence after twelve cycles of reset
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_defaults();
    t_remote_out();
    t_din_remote();
    t_remap();
    t_event_irq();
    end_of_test();
  end
  // the run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    errors++;
    end_of_test();
  end
endmodule
